// >>> drp_pkg.sv
// Purpose: shared constants for the recovery / link / gating control register pair
// Assumes: 25 MHz system clock, 24-bit serial frames, 16-bit registers
// Notes: field positions, reset values and timing figures live here only
package drp_pkg;

   // ==========================================================
   // clock and retry timing
   // ==========================================================
   localparam int DRP_CLK_HZ = 25_000_000;         // system clock rate
   localparam int DRP_RETRY_FREQ_LO_HZ = 1_700;    // slow recovery retry rate
   localparam int DRP_RETRY_FREQ_HI_HZ = 3_000;    // fast recovery retry rate
   // retry period in clock cycles, derived from the rates above
   localparam int DRP_RETRY_CYC_LO = DRP_CLK_HZ / DRP_RETRY_FREQ_LO_HZ;
   localparam int DRP_RETRY_CYC_HI = DRP_CLK_HZ / DRP_RETRY_FREQ_HI_HZ;
   localparam int DRP_RETRY_CNT_W = 16;            // width of the retry period counter

   // ==========================================================
   // serial frame layout
   // ==========================================================
   localparam int DRP_FRAME_BITS = 24;             // bits in one complete frame
   localparam int DRP_HDR_BITS = 8;                // command byte ahead of the data
   localparam int DRP_BITCNT_W = 5;                // bit counter width
   localparam int DRP_RD_FLAG_BIT = 23;            // 1 = read, 0 = write
   localparam int DRP_ADDR_MSB = 21;               // address field top bit
   localparam int DRP_ADDR_LSB = 16;               // address field bottom bit
   localparam int DRP_ADDR_W = 6;                  // address width
   localparam int DRP_DATA_W = 16;                 // register width

   // ==========================================================
   // register map
   // ==========================================================
   localparam logic [5:0] DRP_ADDR_RECOV_CTRL = 6'h03;  // recovery_link_pwm_control
   localparam logic [5:0] DRP_ADDR_GATE_CTRL = 6'h04;   // output_retry_gating_monitor_control
   localparam logic [15:0] DRP_RECOV_RESET = 16'h0040;  // timeout enable set after reset
   localparam logic [15:0] DRP_GATE_RESET = 16'h0000;
   // writable bits; reserved bits are dropped on write and so read zero
   localparam logic [15:0] DRP_RECOV_WMASK = 16'h7FFF;
   localparam logic [15:0] DRP_GATE_WMASK = 16'hFF5F;

   // recovery_link_pwm_control fields
   localparam int DRP_RC_RATE_BIT = 14;            // retry_rate_select
   localparam int DRP_RC_SUPPLY_BIT = 13;          // supply_fault_manual_restart
   localparam int DRP_RC_RETRY_LSB = 8;            // hs_one..hs_five_auto_retry
   localparam int DRP_RC_LINFAST_BIT = 7;          // lin_fast_rate_select
   localparam int DRP_RC_LINTO_BIT = 6;            // lin_dominant_timeout_enable
   localparam int DRP_RC_GLASS_BIT = 5;            // glass_voltage_limit_select
   localparam int DRP_RC_GATE_LSB = 0;             // hs_one..hs_five_gate_enable
   localparam int DRP_LOW_OUTS = 5;                // outputs one to five

   // output_retry_gating_monitor_control fields
   localparam int DRP_GC_RETRY_LSB = 12;           // hs_six..hs_nine_auto_retry
   localparam int DRP_GC_GATE_LSB = 8;             // hs_six..hs_nine gate enables
   localparam int DRP_GC_GLASS_RETRY_BIT = 6;      // glass_driver_auto_retry
   localparam int DRP_GC_GLASS_GATE_BIT = 4;       // glass_driver_gate_enable
   localparam int DRP_GC_CM_LSB = 0;               // current_monitor_sel_0..3
   localparam int DRP_CM_W = 4;
   localparam int DRP_HIGH_OUTS = 4;               // outputs six to nine
   localparam int DRP_NUM_OUTS = 9;                // high-side outputs one to nine

   // pulse input routing per output: 0 = input a, 1 = input b, 2 = input c
   localparam int DRP_PWM_A = 0;
   localparam int DRP_PWM_B = 1;
   localparam int DRP_PWM_C = 2;
   localparam int DRP_OUT6_IDX = 5;                // output six, gated by input b
   localparam int DRP_OUT8_IDX = 7;                // output eight, gated by input c

   // synchroniser width: csn, sclk, mosi, three pulse inputs, supply fault, nine faults
   localparam int DRP_SYNC_W = 16;
   localparam logic [15:0] DRP_SYNC_INIT = 16'h8000;    // csn idles high

endpackage

// >>> drp_sync.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs are asynchronous to clk
// Notes: output follows only when the second and third stages agree
`timescale 1ns/1ps
`default_nettype none
module drp_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] s1_r;  // first stage, read only by the second
   logic [W-1:0] s2_r;  // second stage
   logic [W-1:0] s3_r;  // third stage
   logic [W-1:0] q_nxt;

   // ==========================================================
   // agreement filter
   // ==========================================================
   // a bit changes only when two settled stages agree, which drops single-cycle glitches
   genvar gi;
   generate
      for (gi = 0; gi < W; gi++) begin : g_bit
         assign q_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : q[gi];
      end
   endgenerate

   // stage chain
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s1_r <= INIT;
         s2_r <= INIT;
         s3_r <= INIT;
         q <= INIT;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q <= q_nxt;
      end
   end

endmodule
`default_nettype wire

// >>> drp_retry_timer.sv
// Purpose: overcurrent retry tick generator with two selectable periods
// Assumes: periods are given in clk cycles and fit the counter
// Notes: a rate change takes effect at once; the compare value is picked live each cycle
`timescale 1ns/1ps
`default_nettype none
module drp_retry_timer
   import drp_pkg::*;
#(
   parameter int PERIOD_LO = drp_pkg::DRP_RETRY_CYC_LO,
   parameter int PERIOD_HI = drp_pkg::DRP_RETRY_CYC_HI
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // control
   input wire logic rate_hi,
   // one-cycle retry strobe
   output logic tick
);

   localparam logic [DRP_RETRY_CNT_W-1:0] LAST_LO = DRP_RETRY_CNT_W'(PERIOD_LO - 1);
   localparam logic [DRP_RETRY_CNT_W-1:0] LAST_HI = DRP_RETRY_CNT_W'(PERIOD_HI - 1);

   logic [DRP_RETRY_CNT_W-1:0] cnt_r;   // cycles into the current period
   logic [DRP_RETRY_CNT_W-1:0] cnt_nxt;
   logic wrap;                          // last cycle of the period

   // ==========================================================
   // period counter
   // ==========================================================
   // the compare value is picked live; a shorter period chosen mid-way wraps at once
   assign wrap = rate_hi ? (cnt_r >= LAST_HI) : (cnt_r >= LAST_LO);
   assign cnt_nxt = wrap ? '0 : cnt_r + 1'b1;

   // counter and strobe registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_r <= '0;
         tick <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick <= wrap;
      end
   end

endmodule
`default_nettype wire

// >>> drp_regs.sv
// Purpose: serial-reachable recovery, link and pulse gating control registers
// Assumes: serial mode 0 frames of 24 bits, sclk at most clk/8
// Notes: outputs are drive requests for the high-side stages and config levels
//
// Functional notes
// RULE1: reserved top bit written zero, reads zero
// RULE2: rate bit picks slow or fast retry
// RULE3: supply fault restart automatic or after clear
// RULE4: retry-enabled outputs one to five self-restart
// RULE5: retry-disabled outputs stay off until clear
// RULE6: link bit picks normal or fast rate
// RULE7: timeout enable bit, set after reset
// RULE8: glass limit bit picks low or high
// RULE9: gated outputs follow pulse input a
// RULE10: register at 03h, reset value 0040h
// RULE11: outputs eight, seven, six use c, a, b
`timescale 1ns/1ps
`default_nettype none
module drp_regs
   import drp_pkg::*;
#(
   parameter int RETRY_PERIOD_LO = drp_pkg::DRP_RETRY_CYC_LO,
   parameter int RETRY_PERIOD_HI = drp_pkg::DRP_RETRY_CYC_HI
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // serial port pins
   input wire logic spi_csn,
   input wire logic spi_sclk,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   // pulse gating pins
   input wire logic pulse_gate_input_a,
   input wire logic pulse_gate_input_b,
   input wire logic pulse_gate_input_c,
   // fault detectors from the analog stages
   input wire logic supply_fault,
   input wire logic [drp_pkg::DRP_NUM_OUTS-1:0] hs_overcurrent,
   // same-clock requests from the other control registers
   input wire logic [drp_pkg::DRP_NUM_OUTS-1:0] hs_on_request,
   input wire logic status_clear,
   // high-side drive commands
   output logic [drp_pkg::DRP_NUM_OUTS-1:0] hs_drive,
   output logic supply_outputs_off,
   // configuration levels for the link, glass and monitor blocks
   output logic retry_rate_select,
   output logic lin_fast_rate_select,
   output logic lin_dominant_timeout_enable,
   output logic glass_voltage_limit_select,
   output logic glass_driver_auto_retry,
   output logic glass_driver_gate_enable,
   output logic [drp_pkg::DRP_CM_W-1:0] current_monitor_sel
);

   import drp_pkg::*;

   // ==========================================================
   // input synchronisers
   // ==========================================================
   logic [DRP_SYNC_W-1:0] sync_d;  // raw pins
   logic [DRP_SYNC_W-1:0] sync_q;  // filtered levels
   logic csn_s;                    // chip select, active low
   logic sclk_s;                   // serial clock level
   logic mosi_s;                   // serial data in
   logic [2:0] pwm_s;              // pulse inputs c, b, a
   logic sup_s;                    // supply fault level
   logic [DRP_NUM_OUTS-1:0] oc_s;  // overcurrent levels

   assign sync_d = {spi_csn, spi_sclk, spi_mosi, pulse_gate_input_c, pulse_gate_input_b,
                    pulse_gate_input_a, supply_fault, hs_overcurrent};
   assign {csn_s, sclk_s, mosi_s, pwm_s, sup_s, oc_s} = sync_q;

   // all pins share one filter so their relative timing is preserved
   drp_sync #(
      .W(DRP_SYNC_W),
      .INIT(DRP_SYNC_INIT)
   ) u_sync (
      .clk(clk),
      .resetn(resetn),
      .d(sync_d),
      .q(sync_q)
   );

   // ==========================================================
   // registers
   // ==========================================================
   logic [DRP_DATA_W-1:0] recov_r;   // recovery_link_pwm_control
   logic [DRP_DATA_W-1:0] gate_r;    // output_retry_gating_monitor_control

   // ==========================================================
   // serial frame engine
   // ==========================================================
   logic sclk_d_r;                        // previous filtered sclk
   logic csn_d_r;                         // previous filtered csn
   logic [DRP_BITCNT_W-1:0] bitcnt_r;     // bits sampled in this frame
   logic [DRP_FRAME_BITS-1:0] shin_r;     // received bits
   logic [DRP_DATA_W-1:0] shout_r;        // read data still to send
   logic [DRP_BITCNT_W-1:0] bitcnt_nxt;
   logic [DRP_FRAME_BITS-1:0] shin_nxt;
   logic [DRP_DATA_W-1:0] shout_nxt;
   logic miso_nxt;
   logic sclk_rise;                       // sample edge
   logic sclk_fall;                       // launch edge
   logic frame_act;                       // chip select asserted
   logic frame_end;                       // chip select just released
   logic hdr_done;                        // this rise completes the command byte
   logic in_data;                         // data phase of the frame
   logic [DRP_ADDR_W-1:0] rd_addr;        // address seen at end of command byte
   logic [DRP_DATA_W-1:0] rd_data;        // register read mux
   logic wr_ok;                           // whole write frame received
   logic [DRP_ADDR_W-1:0] wr_addr;
   logic [DRP_DATA_W-1:0] wr_data;
   logic wr_recov;                        // write strobe, address 03h
   logic wr_gate;                         // write strobe, address 04h

   // edge detection works on the filtered levels only
   assign sclk_rise = sclk_s & ~sclk_d_r;
   assign sclk_fall = ~sclk_s & sclk_d_r;
   assign frame_act = ~csn_s;
   assign frame_end = csn_s & ~csn_d_r;
   assign hdr_done = frame_act & sclk_rise & (bitcnt_r == DRP_BITCNT_W'(DRP_HDR_BITS - 1));
   assign in_data = (bitcnt_r >= DRP_BITCNT_W'(DRP_HDR_BITS)) &
                    (bitcnt_r < DRP_BITCNT_W'(DRP_FRAME_BITS));

   // bit counter saturates so an overlong frame cannot alias back to 24
   assign bitcnt_nxt = !frame_act ? '0 :
                       (sclk_rise && bitcnt_r != '1) ? bitcnt_r + 1'b1 : bitcnt_r;
   assign shin_nxt = (frame_act & sclk_rise) ? {shin_r[DRP_FRAME_BITS-2:0], mosi_s} : shin_r;

   // read address is complete with the eighth bit still on mosi
   assign rd_addr = {shin_r[DRP_ADDR_W-2:0], mosi_s};

   // unmapped addresses answer zero
   assign rd_data = (rd_addr == DRP_ADDR_RECOV_CTRL) ? recov_r :
                    (rd_addr == DRP_ADDR_GATE_CTRL) ? gate_r : '0;  // [RULE10]

   // read data is loaded after the command byte and shifted out on falling edges
   assign shout_nxt = hdr_done ? rd_data :
                      (frame_act & sclk_fall & in_data) ? {shout_r[DRP_DATA_W-2:0], 1'b0} : shout_r;
   assign miso_nxt = !frame_act ? 1'b0 :
                     (sclk_fall & in_data) ? shout_r[DRP_DATA_W-1] : spi_miso;

   // writes commit only on release of a frame of exactly 24 bits
   assign wr_ok = frame_end & (bitcnt_r == DRP_BITCNT_W'(DRP_FRAME_BITS)) & ~shin_r[DRP_RD_FLAG_BIT];
   assign wr_addr = shin_r[DRP_ADDR_MSB:DRP_ADDR_LSB];
   assign wr_data = shin_r[DRP_DATA_W-1:0];
   assign wr_recov = wr_ok & (wr_addr == DRP_ADDR_RECOV_CTRL);  // [RULE10]
   assign wr_gate = wr_ok & (wr_addr == DRP_ADDR_GATE_CTRL);

   // frame state
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sclk_d_r <= 1'b0;
         csn_d_r <= 1'b1;
         bitcnt_r <= '0;
         shin_r <= '0;
         shout_r <= '0;
      end else begin
         sclk_d_r <= sclk_s;
         csn_d_r <= csn_s;
         bitcnt_r <= bitcnt_nxt;
         shin_r <= shin_nxt;
         shout_r <= shout_nxt;
      end
   end

   // miso pin and its enable; the pin floats while deselected
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         spi_miso <= 1'b0;
         spi_miso_oe <= 1'b0;
      end else begin
         spi_miso <= miso_nxt;
         spi_miso_oe <= frame_act;
      end
   end

   // ==========================================================
   // register storage
   // ==========================================================
   // reserved bits are masked on write so a careless host cannot make them read one
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         recov_r <= DRP_RECOV_RESET;  // [RULE10] [RULE7]
         gate_r <= DRP_GATE_RESET;
      end else begin
         if (wr_recov) begin
            recov_r <= wr_data & DRP_RECOV_WMASK;  // [RULE1]
         end
         if (wr_gate) begin
            gate_r <= wr_data & DRP_GATE_WMASK;
         end
      end
   end

   // ==========================================================
   // configuration level outputs
   // ==========================================================
   // one cycle behind the registers so every output leaves a flip-flop
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         retry_rate_select <= 1'b0;
         lin_fast_rate_select <= 1'b0;
         lin_dominant_timeout_enable <= DRP_RECOV_RESET[DRP_RC_LINTO_BIT];
         glass_voltage_limit_select <= 1'b0;
         glass_driver_auto_retry <= 1'b0;
         glass_driver_gate_enable <= 1'b0;
         current_monitor_sel <= '0;
      end else begin
         retry_rate_select <= recov_r[DRP_RC_RATE_BIT];                   // [RULE2]
         lin_fast_rate_select <= recov_r[DRP_RC_LINFAST_BIT];             // [RULE6]
         lin_dominant_timeout_enable <= recov_r[DRP_RC_LINTO_BIT];        // [RULE7]
         glass_voltage_limit_select <= recov_r[DRP_RC_GLASS_BIT];         // [RULE8]
         glass_driver_auto_retry <= gate_r[DRP_GC_GLASS_RETRY_BIT];
         glass_driver_gate_enable <= gate_r[DRP_GC_GLASS_GATE_BIT];
         current_monitor_sel <= gate_r[DRP_GC_CM_LSB +: DRP_CM_W];
      end
   end

   // ==========================================================
   // retry timer
   // ==========================================================
   logic retry_tick;  // one-cycle strobe at the selected recovery rate

   drp_retry_timer #(
      .PERIOD_LO(RETRY_PERIOD_LO),
      .PERIOD_HI(RETRY_PERIOD_HI)
   ) u_retry (
      .clk(clk),
      .resetn(resetn),
      .rate_hi(recov_r[DRP_RC_RATE_BIT]),  // [RULE2]
      .tick(retry_tick)
   );

   // ==========================================================
   // supply fault hold-off
   // ==========================================================
   logic sup_off_r;  // outputs held off by a supply fault
   logic sup_off_nxt;
   logic sup_manual;

   assign sup_manual = recov_r[DRP_RC_SUPPLY_BIT];
   // a live fault always wins over a clear in the same cycle
   assign sup_off_nxt = sup_s ? 1'b1 :
                        (!sup_manual || status_clear) ? 1'b0 : sup_off_r;  // [RULE3]

   // hold-off flag and its copy on the port
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sup_off_r <= 1'b0;
         supply_outputs_off <= 1'b0;
      end else begin
         sup_off_r <= sup_off_nxt;
         supply_outputs_off <= sup_off_nxt;
      end
   end

   // ==========================================================
   // per-output overcurrent latch and pulse gating
   // ==========================================================
   logic [DRP_NUM_OUTS-1:0] auto_retry;  // auto-retry enables, output one at bit 0
   logic [DRP_NUM_OUTS-1:0] gate_en;     // pulse gate enables
   logic [DRP_NUM_OUTS-1:0] pwm_level;   // pulse input routed to each output
   logic [DRP_NUM_OUTS-1:0] oc_off_r;    // latched overcurrent shut-off
   logic [DRP_NUM_OUTS-1:0] oc_off_nxt;
   logic [DRP_NUM_OUTS-1:0] drive_nxt;

   assign auto_retry = {gate_r[DRP_GC_RETRY_LSB +: DRP_HIGH_OUTS],
                        recov_r[DRP_RC_RETRY_LSB +: DRP_LOW_OUTS]};
   assign gate_en = {gate_r[DRP_GC_GATE_LSB +: DRP_HIGH_OUTS],
                     recov_r[DRP_RC_GATE_LSB +: DRP_LOW_OUTS]};

   genvar gi;
   generate
      for (gi = 0; gi < DRP_NUM_OUTS; gi++) begin : g_out
         // output six uses input b, output eight input c, all others input a
         if (gi == DRP_OUT6_IDX) begin : g_b
            assign pwm_level[gi] = pwm_s[DRP_PWM_B];  // [RULE11]
         end else if (gi == DRP_OUT8_IDX) begin : g_c
            assign pwm_level[gi] = pwm_s[DRP_PWM_C];  // [RULE11]
         end else begin : g_a
            assign pwm_level[gi] = pwm_s[DRP_PWM_A];  // [RULE9] [RULE11]
         end
         // a fault sets the latch and wins over a clear or retry in the same cycle;
         // with auto-retry the latch drops on a tick once the fault has gone; a persisting fault keeps it set
         assign oc_off_nxt[gi] = oc_s[gi] ? 1'b1 :
                                 (status_clear || (auto_retry[gi] && retry_tick)) ? 1'b0 :
                                 oc_off_r[gi];  // [RULE4] [RULE5]
         // gated outputs follow the pulse level only while also requested on
         assign drive_nxt[gi] = hs_on_request[gi] & ~oc_off_nxt[gi] & ~sup_off_nxt &
                                (~gate_en[gi] | pwm_level[gi]);  // [RULE9] [RULE3]
      end
   endgenerate

   // latches and drive commands
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         oc_off_r <= '0;
         hs_drive <= '0;
      end else begin
         oc_off_r <= oc_off_nxt;
         hs_drive <= drive_nxt;
      end
   end

endmodule
`default_nettype wire

// >>> drp_spi_host.sv
// Purpose: serial host model that sends 24-bit frames and collects read data
// Assumes: mode 0, half period of 8 clocks, well inside the filter limit
// Notes: mosi shows the inverse of its last bit between frames
`timescale 1ns/1ps
`default_nettype none
module drp_spi_host (
   // clock
   input wire logic clk,
   // serial pins
   output logic csn,
   output logic sclk,
   output logic mosi,
   input wire logic miso
);
   initial begin
      csn = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
   end
   // one whole frame, msb first, read bits caught on each rising sclk
   task automatic xfer(input logic [23:0] frm, output logic [15:0] rd);
      rd = 16'h0000;
      @(negedge clk) csn = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         mosi = frm[i];
         repeat (8) @(negedge clk);
         sclk = 1'b1;
         if (i < 16) rd[i] = miso;
         repeat (8) @(negedge clk);
         sclk = 1'b0;
      end
      repeat (8) @(negedge clk);
      csn = 1'b1;
      mosi = ~mosi;
      // gap long enough for the commit to land before the next frame
      repeat (12) @(negedge clk);
   endtask
endmodule
`default_nettype wire

// >>> drp_regs_checker.sv
// Purpose: port-level assertions for the recovery and gating registers
// Assumes: input filter latency of about four clocks
// Notes: bound onto drp_regs after the endmodule
`timescale 1ns/1ps
`default_nettype none
module drp_regs_checker (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // watched pins
   input wire logic spi_csn,
   input wire logic spi_miso_oe,
   input wire logic supply_fault,
   input wire logic [8:0] hs_overcurrent,
   input wire logic [8:0] hs_on_request,
   input wire logic [8:0] hs_drive,
   input wire logic supply_outputs_off,
   input wire logic retry_rate_select,
   input wire logic lin_fast_rate_select,
   input wire logic lin_dominant_timeout_enable,
   input wire logic glass_voltage_limit_select
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // faults held past the filter and one register stage
   sequence s_oc_held; hs_overcurrent[0] [*6]; endsequence
   sequence s_supply_held; supply_fault [*8]; endsequence
   a_reset_values: assert property ($rose(resetn) |-> lin_dominant_timeout_enable && hs_drive == 9'h000)
      else $error("reset values wrong");
   a_drive_needs_req: assert property ((hs_drive & ~$past(hs_on_request)) == 9'h000)
      else $error("drive without request");
   a_oc_cuts_drive: assert property (s_oc_held |=> !hs_drive[0])
      else $error("overcurrent did not cut output one");
   a_supply_cuts_all: assert property (s_supply_held |=> supply_outputs_off && hs_drive == 9'h000)
      else $error("supply fault did not cut outputs");
   // config levels may only move once a frame has closed
   a_rate_frame_only: assert property ($changed(retry_rate_select) |-> spi_csn)
      else $error("rate select moved inside a frame");
   a_link_frame_only: assert property ($changed(lin_fast_rate_select) |-> spi_csn)
      else $error("link rate moved inside a frame");
   a_timeout_frame_only: assert property ($changed(lin_dominant_timeout_enable) |-> spi_csn)
      else $error("timeout enable moved inside a frame");
   a_glass_frame_only: assert property ($changed(glass_voltage_limit_select) |-> spi_csn)
      else $error("glass limit moved inside a frame");
   a_oe_follows_csn: assert property ($stable(spi_csn) [*4] |=> spi_miso_oe == !$past(spi_csn))
      else $error("miso enable wrong");
endmodule
bind drp_regs drp_regs_checker u_chk (.clk(clk), .resetn(resetn), .spi_csn(spi_csn), .supply_fault(supply_fault),
   .hs_overcurrent(hs_overcurrent), .hs_on_request(hs_on_request), .hs_drive(hs_drive), .spi_miso_oe(spi_miso_oe),
   .supply_outputs_off(supply_outputs_off), .retry_rate_select(retry_rate_select),
   .lin_fast_rate_select(lin_fast_rate_select), .lin_dominant_timeout_enable(lin_dominant_timeout_enable),
   .glass_voltage_limit_select(glass_voltage_limit_select));
`default_nettype wire

// >>> drp_regs_tb.sv
// Purpose: self-checking bench for the recovery, link and gating registers
// Assumes: retry periods shortened to 40 and 20 clocks
// Notes: frames come from the host model; drive at falling clk
`timescale 1ns/1ps
`default_nettype none
module drp_regs_tb;
   import drp_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic csn, sclk, mosi, miso, rate, linf, lint, glv, gar, gge, offs;
   logic sfault = 1'b0;
   logic sclr = 1'b0;
   logic [2:0] pg = 3'h0;
   logic [8:0] oc = 9'h000;
   logic [8:0] req = 9'h000;
   logic [8:0] drv;
   logic [3:0] cm;
   logic [15:0] r3 = 16'h0040;
   logic [15:0] r4 = 16'h0000;
   logic [15:0] got;
   int failures = 0;
   int n_compared = 0;
   int seed = 32'h2a0c1772;
   int n;
   always #20 clk = ~clk;
   drp_spi_host host (.clk(clk), .csn(csn), .sclk(sclk), .mosi(mosi), .miso(miso));
   drp_regs #(.RETRY_PERIOD_LO(40), .RETRY_PERIOD_HI(20)) uut (.clk(clk), .resetn(resetn), .spi_csn(csn),
      .spi_sclk(sclk), .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(), .pulse_gate_input_a(pg[0]),
      .pulse_gate_input_b(pg[1]), .pulse_gate_input_c(pg[2]), .supply_fault(sfault), .hs_overcurrent(oc),
      .hs_on_request(req), .status_clear(sclr), .hs_drive(drv), .supply_outputs_off(offs),
      .retry_rate_select(rate), .lin_fast_rate_select(linf), .lin_dominant_timeout_enable(lint),
      .glass_voltage_limit_select(glv), .glass_driver_auto_retry(gar), .glass_driver_gate_enable(gge),
      .current_monitor_sel(cm));
   // expected drive: six on input b, eight on input c, the rest on input a
   function automatic logic [8:0] exp_drive(input logic [2:0] p);
      return {p[0], p[2], p[0], p[1], {5{p[0]}}};
   endfunction
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // reserved bits are dropped by the device, so the model drops them too
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      host.xfer({2'b00, a, d}, got);
      if (a == 6'h03) r3 = d & 16'h7FFF;
      if (a == 6'h04) r4 = d & DRP_GATE_WMASK;
   endtask
   task automatic rd(input logic [5:0] a, input logic [15:0] e);
      host.xfer({2'b10, a, 16'($random(seed))}, got);
      chk("read", e, got);
   endtask
   // fault on output one or on supply, then watch the restart path
   task automatic hit(input logic sup, input logic [15:0] cfg, input logic man, input int lim);
      wr(6'h03, cfg);
      oc[0] = ~sup;
      sfault = sup;
      repeat (12) @(negedge clk);
      chk("cut", 16'h0000, 16'(drv[0]));
      oc[0] = 1'b0;
      sfault = 1'b0;
      n = 0;
      while (drv[0] !== 1'b1 && n < lim) begin
         @(negedge clk);
         n++;
      end
      chk("self_restart", 16'(!man), 16'(n < lim));
      sclr = 1'b1;
      @(negedge clk) sclr = 1'b0;
      repeat (8) @(negedge clk);
      chk("after_clear", 16'h0001, 16'(drv[0]));
   endtask
   task automatic end_sim;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      #4_000_000;
      failures++;
      end_sim();
   end
   initial begin
      repeat (2) @(negedge clk);
      resetn = 1'b1;
      repeat (6) @(negedge clk);
      chk("timeout_en", 16'h0001, 16'(lint));
      rd(6'h03, 16'h0040);
      rd(6'h04, 16'h0000);
      wr(6'h03, 16'hFFFF);
      rd(6'h03, 16'h7FFF);
      for (int i = 0; i < 12; i++) begin
         wr(6'h03 + 6'(i % 3), 16'($random(seed)) & 16'h7FFF);
         rd(6'h03, r3);
         rd(6'h04, r4);
         rd(6'h05, 16'h0000);
         chk("cfg3", {r3[14], r3[7], r3[6], r3[5]}, {rate, linf, lint, glv});
         chk("cfg4", {r4[6], r4[4], r4[3:0]}, {gar, gge, cm});
      end
      req = 9'h1FF;
      wr(6'h03, 16'h001F);
      wr(6'h04, 16'h0F00);
      for (int k = 0; k < 8; k++) begin
         pg = 3'(k);
         repeat (8) @(negedge clk);
         chk("gated", 16'(exp_drive(pg)), 16'(drv));
      end
      wr(6'h04, 16'h0000);
      hit(1'b0, 16'h4100, 1'b0, 28);
      hit(1'b0, 16'h0100, 1'b0, 48);
      hit(1'b0, 16'h0000, 1'b1, 48);
      hit(1'b1, 16'h0000, 1'b0, 48);
      hit(1'b1, 16'h2000, 1'b1, 48);
      end_sim();
   end
endmodule
`default_nettype wire
